// >>> bench/bdts_term.sv
`timescale 1ns/1ns
`include "bdts_cfg.svh"
// terminal side: axi4-lite master that issues apdu traffic to the card
module bdts_term
(
   // clock
   input wire logic aclk,
   // write channels
   output logic [4:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // read channels
   output logic [4:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // idle bus at time zero; full strobes since every register is one word
   initial
   begin
      awaddr = 5'h00;
      awvalid = 1'b0;
      wdata = 32'h00000000;
      wstrb = 4'hf;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 5'h00;
      arvalid = 1'b0;
      rready = 1'b0;
   end

   // one write; payload inverted once taken so stale values never match
   task automatic wr(input logic [4:0] a, input logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      awaddr <= ~a;
      wdata <= ~d;
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask: wr

   // one read; data taken at the edge where rvalid is seen
   task automatic rd(input logic [4:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      araddr <= ~a;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask: rd

   // apdu header: p1 in the low byte, remaining block count above it
   task automatic cmd(input logic [7:0] p1, input logic [7:0] p2);
      logic [1:0] r;
      wr(`BDTS_A_CMD, {16'h0000, p2, p1}, r);
   endtask: cmd

   // one command-data byte, the final one flagged
   task automatic put(input logic [7:0] b, input logic last);
      logic [1:0] r;
      wr(`BDTS_A_DATA, {23'h000000, last, b}, r);
   endtask: put

   // single-block tlv frame: tag, one or two length bytes, n value bytes
   task automatic frame(input logic [1:0] s, input logic [7:0] tag,
      input logic [7:0] l1, input logic [7:0] l2, input int n);
      cmd({s, 6'h04}, 8'h00); // data set, retransmit clear
      put(tag, 1'b0); // same tag for the session
      put(l1, 1'b0);
      if (l1 === `BDTS_LEN_EXT)
         put(l2, 1'b0);
      for (int i = 0; i < n; i++)
         put(i[7:0], i == n - 1);
   endtask: frame
endmodule: bdts_term

// >>> bench/tb_top.sv
`timescale 1ns/1ns
`include "bdts_cfg.svh"
// top bench: card block driven by the terminal model
module tb_top;
   logic aclk;
   logic aresetn;
   logic [4:0] awaddr;
   logic awvalid;
   logic awready;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic wvalid;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready;
   logic [4:0] araddr;
   logic arvalid;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready;
   int n_mismatch;
   int check_count;
   logic [31:0] v;
   logic [1:0] r;

   // card under test
   bdts_core uut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   // terminal model
   bdts_term term
   (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready)
   );

   // 125 mhz clock
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask: chk

   // read a register, check data and response code
   task automatic rdc(input logic [4:0] a, input logic [31:0] e,
      input logic [1:0] er);
      term.rd(a, v, r);
      chk(v, e);
      chk({30'h0, r}, {30'h0, er});
   endtask: rdc

   // write a register, check response code
   task automatic wrc(input logic [4:0] a, input logic [31:0] d,
      input logic [1:0] er);
      term.wr(a, d, r);
      chk({30'h0, r}, {30'h0, er});
   endtask: wrc

   // status word check
   task automatic sw(input logic [15:0] e);
      rdc(`BDTS_A_CMD, {16'h0000, e}, `BDTS_RESP_OKAY);
   endtask: sw

   // ongoing-transaction word from its fields
   function automatic logic [15:0] osw(input logic rs, input logic pr,
      input logic [1:0] s, input logic mo);
      return {`BDTS_SW1_ONGOING, 3'b000, rs, pr, s, mo};
   endfunction: osw

   // verdict, reached from the main sequence or the watchdog
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask: wrap_up

   // watchdog, far beyond the roughly 1350 cycles the tests need
   initial
   begin
      repeat (30000) @(posedge aclk);
      n_mismatch++;
      wrap_up();
   end

   // main sequence
   initial
   begin
      n_mismatch = 0;
      check_count = 0;
      aresetn = 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      sw(`BDTS_SW_OK);
      rdc(`BDTS_A_SEL, {16'h0, `BDTS_TAG_SC, `BDTS_RESP_LEN}, 2'h0);
      rdc(`BDTS_A_CSIZE, {24'h0, `BDTS_CSIZE_RST}, 2'h0);
      rdc(`BDTS_A_TAGS, 32'h0, `BDTS_RESP_OKAY);
      rdc(`BDTS_A_RWORD, 32'h0, `BDTS_RESP_SLVERR);
      rdc(5'h02, 32'h0, `BDTS_RESP_SLVERR);
      wrc(5'h1e, 32'h0, `BDTS_RESP_SLVERR);
      $display("test reset done");
      // framing: short, two-byte lengths, longest one-byte length sent in long form
      term.frame(2'd1, 8'h80, 8'h02, 8'h00, 2);
      sw(osw(1'b0, 1'b0, 2'd1, 1'b0));
      term.frame(2'd2, 8'h80, 8'h81, 8'h80, 128);
      sw(osw(1'b0, 1'b0, 2'd2, 1'b0));
      term.frame(2'd2, 8'h80, 8'h81, 8'h7f, 127);
      sw(osw(1'b1, 1'b0, 2'd2, 1'b0));
      term.frame(2'd0, 8'h81, 8'h01, 8'h00, 1);
      sw(osw(1'b1, 1'b0, 2'd0, 1'b0));
      rdc(`BDTS_A_TAGS, 32'h00808000, `BDTS_RESP_OKAY);
      wrc(`BDTS_A_SEL, 32'h2, `BDTS_RESP_OKAY);
      wrc(`BDTS_A_CSIZE, 32'h3, `BDTS_RESP_OKAY);
      term.frame(2'd2, 8'h80, 8'h04, 8'h00, 4);
      sw(osw(1'b1, 1'b0, 2'd2, 1'b0));
      wrc(`BDTS_A_FLAGS, 32'h1, `BDTS_RESP_OKAY);
      term.frame(2'd1, 8'h80, 8'h01, 8'h00, 1);
      sw(osw(1'b0, 1'b1, 2'd1, 1'b0));
      wrc(`BDTS_A_FLAGS, 32'h0, `BDTS_RESP_OKAY);
      $display("test framing done");
      // fetch, retransmit, fetch last
      wrc(`BDTS_A_SEL, 32'h3, `BDTS_RESP_OKAY);
      wrc(`BDTS_A_PEND, 32'h2, `BDTS_RESP_OKAY);
      wrc(`BDTS_A_RWORD, 32'h11223344, `BDTS_RESP_OKAY);
      term.cmd(8'hc0, 8'h00);
      sw(osw(1'b0, 1'b0, 2'd3, 1'b1));
      rdc(`BDTS_A_DATA, 32'h11223344, `BDTS_RESP_OKAY);
      rdc(`BDTS_A_PEND, 32'h1, `BDTS_RESP_OKAY);
      wrc(`BDTS_A_RWORD, 32'h55667788, `BDTS_RESP_OKAY);
      term.cmd(8'hc1, 8'h00);
      sw(osw(1'b0, 1'b0, 2'd3, 1'b1));
      rdc(`BDTS_A_DATA, 32'h11223344, `BDTS_RESP_OKAY);
      term.cmd(8'hc0, 8'h00);
      sw(osw(1'b0, 1'b0, 2'd3, 1'b0));
      rdc(`BDTS_A_DATA, 32'h55667788, `BDTS_RESP_OKAY);
      $display("test fetch done");
      // refused headers
      term.cmd(8'h45, 8'h00);
      sw(`BDTS_SW_BADP1);
      term.cmd(8'h08, 8'h00);
      sw(`BDTS_SW_BADP1);
      term.cmd(8'h40, 8'h01);
      sw(`BDTS_SW_NODATA);
      // abort in mid-frame, later data ignored
      wrc(`BDTS_A_SEL, 32'h0, `BDTS_RESP_OKAY);
      wrc(`BDTS_A_PEND, 32'h1, `BDTS_RESP_OKAY);
      term.cmd(8'h04, 8'h01);
      term.put(8'h80, 1'b0);
      // p2 kept, tag seen, length byte next, session 0
      rdc(`BDTS_A_FLAGS, 32'h00000130, `BDTS_RESP_OKAY);
      term.cmd(8'h02, 8'h00);
      sw(`BDTS_SW_OK);
      rdc(`BDTS_A_PEND, 32'h0, `BDTS_RESP_OKAY);
      term.put(8'h00, 1'b1);
      sw(`BDTS_SW_OK);
      // memory exhausted aborts the session
      wrc(`BDTS_A_FLAGS, 32'h2, `BDTS_RESP_OKAY);
      term.cmd(8'h44, 8'h00);
      sw(`BDTS_SW_NOMEM);
      term.put(8'h00, 1'b1);
      sw(`BDTS_SW_NOMEM);
      wrc(`BDTS_A_FLAGS, 32'h0, `BDTS_RESP_OKAY);
      $display("test errors done");
      wrap_up();
   end
endmodule: tb_top

// >>> src/bdts_cfg.svh
`ifndef BDTS_CFG_SVH
`define BDTS_CFG_SVH
// register byte offsets (address bits [4:0])
`define BDTS_A_CMD 5'h00
`define BDTS_A_DATA 5'h04
`define BDTS_A_SEL 5'h08
`define BDTS_A_PEND 5'h0c
`define BDTS_A_RWORD 5'h10
`define BDTS_A_CSIZE 5'h14
`define BDTS_A_FLAGS 5'h18
`define BDTS_A_TAGS 5'h1c
// p1 field positions
`define BDTS_P1_RETX 0
`define BDTS_P1_ABORT 1
`define BDTS_P1_DATA 2
`define BDTS_P1_RSV_HI 5
`define BDTS_P1_RSV_LO 3
`define BDTS_P1_SESS_HI 7
`define BDTS_P1_SESS_LO 6
// data register: byte in [7:0], last-byte flag
`define BDTS_D_LAST 8
// flags register bits
`define BDTS_F_PRO 0
`define BDTS_F_NOMEM 1
// status words and tlv codes
`define BDTS_SW1_ONGOING 8'h92
`define BDTS_SW_OK 16'h9000
`define BDTS_SW_NOMEM 16'h6a84
`define BDTS_SW_BADP1 16'h6a86
`define BDTS_SW_NODATA 16'h6700
`define BDTS_TAG_SC 8'h80
`define BDTS_TAG_NONE 8'h00
`define BDTS_TAG_MORE 5'h1f
`define BDTS_TAG_LAST_IDX 2'h2
`define BDTS_LEN_SHORT_MAX 8'h7f
`define BDTS_LEN_EXT 8'h81
`define BDTS_RESP_LEN 8'h04
`define BDTS_CSIZE_RST 8'hff
// axi responses
`define BDTS_RESP_OKAY 2'h0
`define BDTS_RESP_SLVERR 2'h2
`endif

// >>> src/bdts_core.sv
`timescale 1ns/1ns
`include "bdts_cfg.svh"
module bdts_core
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // bus state
   logic wa_r, wa_nxt, bvalid_r, bvalid_nxt, ar_r, ar_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic we;
   // core state
   bdts_pkg::bdts_state_e st_r, st_nxt;
   logic [1:0] cur_s_r, cur_s_nxt, sel_r, sel_nxt, tcnt_r, tcnt_nxt;
   logic [7:0] ftag_r, ftag_nxt, len_r, len_nxt, vcnt_r, vcnt_nxt;
   logic [7:0] p2_r, p2_nxt, rtag_r, rtag_nxt;
   logic ferr_r, ferr_nxt, pro_r, pro_nxt, nomem_r, nomem_nxt;
   logic [15:0] sw_r, sw_nxt;
   logic [31:0] resp_r, resp_nxt;
   logic [7:0] tag_r [4];
   logic [7:0] tag_nxt [4];
   logic [7:0] pend_r [4];
   logic [7:0] pend_nxt [4];
   logic [7:0] csize_r [4];
   logic [7:0] csize_nxt [4];
   logic [7:0] lsw2_r [4];
   logic [7:0] lsw2_nxt [4];
   logic [31:0] rmem_r [4];
   logic [31:0] rmem_nxt [4];
   logic [31:0] last_r [4];
   logic [31:0] last_nxt [4];
   // decoded command, shared with the checks
   logic cmd_we, end_c, ans_c, res_c, fetch_c;
   logic [7:0] p1_c;
   logic [1:0] s_c, as_c;

   // sw2: rsv, resend, proactive, session, more
   function automatic logic [7:0] sw2_f(input logic res, input logic pro,
      input logic [3:0] pv, input logic [1:0] cs);
      logic [1:0] ps;
      ps = cs;
      for (int i = 3; i >= 0; i--)
      begin
         if (pv[i])
            ps = 2'(i); // lowest session with data waiting
      end
      sw2_f = {3'h0, res, pro, ps, |pv};
   endfunction: sw2_f

   // a write is taken when both channels meet the ready pulse with a strobe set
   assign we = wa_r && s_axi_awvalid && s_axi_wvalid && |s_axi_wstrb;
   assign p1_c = s_axi_wdata[7:0];
   assign s_c = p1_c[`BDTS_P1_SESS_HI:`BDTS_P1_SESS_LO];
   assign cmd_we = we && s_axi_awaddr == `BDTS_A_CMD;

   // bus handshake: one write and one read in flight at most
   always_comb
   begin
      wa_nxt = 1'b0;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      ar_nxt = 1'b0;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (!wa_r && !bvalid_r && s_axi_awvalid && s_axi_wvalid)
         wa_nxt = 1'b1;
      if (wa_r && s_axi_awvalid && s_axi_wvalid)
      begin
         bvalid_nxt = 1'b1;
         bresp_nxt = (s_axi_awaddr > `BDTS_A_FLAGS ||
            s_axi_awaddr[1:0] != 2'h0) ? `BDTS_RESP_SLVERR :
            `BDTS_RESP_OKAY;
      end
      else if (bvalid_r && s_axi_bready)
         bvalid_nxt = 1'b0;
      if (!ar_r && !rvalid_r && s_axi_arvalid)
         ar_nxt = 1'b1;
      if (ar_r && s_axi_arvalid)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt = `BDTS_RESP_OKAY;
         case (s_axi_araddr)
            `BDTS_A_CMD: rdata_nxt = {16'h0, sw_r};
            `BDTS_A_DATA: rdata_nxt = resp_r;
            `BDTS_A_SEL: rdata_nxt = {16'h0, rtag_r, `BDTS_RESP_LEN};
            `BDTS_A_PEND: rdata_nxt = {24'h0, pend_r[sel_r]};
            `BDTS_A_CSIZE: rdata_nxt = {24'h0, csize_r[sel_r]};
            // header p2 shows here so the block count can be read back
            `BDTS_A_FLAGS: rdata_nxt = {16'h0, p2_r, 1'b0, st_r, cur_s_r,
               nomem_r, pro_r};
            `BDTS_A_TAGS: rdata_nxt = {tag_r[3], tag_r[2], tag_r[1], tag_r[0]};
            default:
            begin
               rdata_nxt = 32'h0;
               rresp_nxt = `BDTS_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_r && s_axi_rready)
         rvalid_nxt = 1'b0;
   end

   // bus registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wa_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `BDTS_RESP_OKAY;
         ar_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= `BDTS_RESP_OKAY;
      end
      else
      begin
         wa_r <= wa_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         ar_r <= ar_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_awready = wa_r;
   assign s_axi_wready = wa_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = ar_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // command decode, frame parser and per-session bookkeeping
   always_comb
   begin
      logic [7:0] b;
      logic [3:0] pv;
      logic bad;
      b = s_axi_wdata[7:0];
      pv = 4'h0;
      bad = 1'b0;
      st_nxt = st_r;
      cur_s_nxt = cur_s_r;
      sel_nxt = sel_r;
      tcnt_nxt = tcnt_r;
      ftag_nxt = ftag_r;
      len_nxt = len_r;
      vcnt_nxt = vcnt_r;
      p2_nxt = p2_r;
      rtag_nxt = rtag_r;
      ferr_nxt = ferr_r;
      pro_nxt = pro_r;
      nomem_nxt = nomem_r;
      sw_nxt = sw_r;
      resp_nxt = resp_r;
      tag_nxt = tag_r;
      pend_nxt = pend_r;
      csize_nxt = csize_r;
      lsw2_nxt = lsw2_r;
      rmem_nxt = rmem_r;
      last_nxt = last_r;
      end_c = 1'b0;
      ans_c = 1'b0;
      res_c = 1'b0;
      fetch_c = 1'b0;
      as_c = s_c;
      if (cmd_we)
      begin
         // a new command header drops any half-received frame
         st_nxt = bdts_pkg::ST_IDLE;
         if (p1_c[`BDTS_P1_RSV_HI:`BDTS_P1_RSV_LO] != 3'h0 ||
            (p1_c[`BDTS_P1_DATA] && p1_c[`BDTS_P1_RETX]))
            sw_nxt = `BDTS_SW_BADP1;
         else if (p1_c[`BDTS_P1_ABORT])
         begin
            // association stays open; only transaction data goes
            tag_nxt[s_c] = `BDTS_TAG_NONE;
            pend_nxt[s_c] = 8'h0;
            last_nxt[s_c] = 32'h0;
            lsw2_nxt[s_c] = 8'h0;
            sw_nxt = `BDTS_SW_OK;
         end
         else if (p1_c[`BDTS_P1_DATA])
         begin
            if (nomem_r)
            begin
               tag_nxt[s_c] = `BDTS_TAG_NONE;
               pend_nxt[s_c] = 8'h0;
               sw_nxt = `BDTS_SW_NOMEM;
            end
            else
            begin
               st_nxt = bdts_pkg::ST_TAG;
               cur_s_nxt = s_c;
               p2_nxt = s_axi_wdata[15:8];
               tcnt_nxt = 2'h0;
               vcnt_nxt = 8'h0;
               len_nxt = 8'h0;
               ferr_nxt = 1'b0;
            end
         end
         else if (s_axi_wdata[15:8] != 8'h0)
            sw_nxt = `BDTS_SW_NODATA; // blocks still owed
         else if (p1_c[`BDTS_P1_RETX])
         begin
            resp_nxt = last_r[s_c];
            sw_nxt = {`BDTS_SW1_ONGOING, lsw2_r[s_c]};
         end
         else
         begin
            // fetch allowed mid-transaction of any session
            ans_c = 1'b1;
            if (pend_r[s_c] != 8'h0)
            begin
               fetch_c = 1'b1;
               pend_nxt[s_c] = pend_r[s_c] - 8'h1;
               resp_nxt = rmem_r[s_c];
               last_nxt[s_c] = rmem_r[s_c];
               rtag_nxt = (tag_r[s_c] == `BDTS_TAG_NONE) ?
                  `BDTS_TAG_SC : tag_r[s_c];
            end
         end
      end
      else if (we && s_axi_awaddr == `BDTS_A_DATA &&
         st_r != bdts_pkg::ST_IDLE)
      begin
         case (st_r)
            bdts_pkg::ST_TAG:
            begin
               tcnt_nxt = tcnt_r + 2'h1;
               if (tcnt_r == 2'h0)
                  ftag_nxt = b;
               else
                  ferr_nxt = 1'b1; // multi-byte tags are reserved
               if (tcnt_r == `BDTS_TAG_LAST_IDX)
               begin
                  st_nxt = bdts_pkg::ST_LEN; // three tag bytes at most
                  if (b[7])
                     ferr_nxt = 1'b1;
               end
               else if (tcnt_r == 2'h0 ? b[4:0] != `BDTS_TAG_MORE : !b[7])
                  st_nxt = bdts_pkg::ST_LEN;
            end
            bdts_pkg::ST_LEN:
            begin
               st_nxt = bdts_pkg::ST_VAL;
               if (b <= `BDTS_LEN_SHORT_MAX)
                  len_nxt = b;
               else if (b == `BDTS_LEN_EXT)
                  st_nxt = bdts_pkg::ST_LEN2;
               else
                  ferr_nxt = 1'b1;
            end
            bdts_pkg::ST_LEN2:
            begin
               st_nxt = bdts_pkg::ST_VAL;
               len_nxt = b;
               if (!b[7])
                  ferr_nxt = 1'b1; // short length in long form
            end
            bdts_pkg::ST_VAL:
            begin
               if (vcnt_r == len_r)
                  ferr_nxt = 1'b1; // more value bytes than length
               else
                  vcnt_nxt = vcnt_r + 8'h1;
            end
            default: st_nxt = bdts_pkg::ST_IDLE;
         endcase
         if (s_axi_wdata[`BDTS_D_LAST])
         begin
            end_c = 1'b1;
            as_c = cur_s_r;
            bad = ferr_nxt || st_nxt != bdts_pkg::ST_VAL ||
               vcnt_nxt != len_nxt || ftag_nxt != `BDTS_TAG_SC ||
               (tag_r[cur_s_r] != `BDTS_TAG_NONE &&
               ftag_nxt != tag_r[cur_s_r]) ||
               len_nxt > csize_r[cur_s_r];
            if (!bad)
               tag_nxt[cur_s_r] = ftag_nxt;
            // final or not, a block is answered with 92 xx
            ans_c = 1'b1;
            res_c = bad; // ask the terminal to resend
            st_nxt = bdts_pkg::ST_IDLE;
         end
      end
      else if (we)
      begin
         case (s_axi_awaddr)
            `BDTS_A_SEL: sel_nxt = s_axi_wdata[1:0];
            `BDTS_A_PEND: pend_nxt[sel_r] = s_axi_wdata[7:0];
            `BDTS_A_RWORD: rmem_nxt[sel_r] = s_axi_wdata;
            `BDTS_A_CSIZE: csize_nxt[sel_r] = s_axi_wdata[7:0];
            `BDTS_A_FLAGS:
            begin
               pro_nxt = s_axi_wdata[`BDTS_F_PRO];
               nomem_nxt = s_axi_wdata[`BDTS_F_NOMEM];
            end
            default: ;
         endcase
      end
      // pending data of any session shows in every fetch and end-of-frame answer
      for (int i = 0; i < 4; i++)
         pv[i] = |pend_nxt[i];
      if (ans_c)
      begin
         sw_nxt = {`BDTS_SW1_ONGOING, sw2_f(res_c, pro_r, pv, as_c)};
         if (fetch_c)
            lsw2_nxt[as_c] = sw_nxt[7:0];
      end
   end

   // core registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= bdts_pkg::ST_IDLE;
         cur_s_r <= 2'h0;
         sel_r <= 2'h0;
         tcnt_r <= 2'h0;
         ftag_r <= `BDTS_TAG_NONE;
         len_r <= 8'h0;
         vcnt_r <= 8'h0;
         p2_r <= 8'h0;
         rtag_r <= `BDTS_TAG_SC;
         ferr_r <= 1'b0;
         pro_r <= 1'b0;
         nomem_r <= 1'b0;
         sw_r <= `BDTS_SW_OK;
         resp_r <= 32'h0;
         for (int i = 0; i < 4; i++)
         begin
            tag_r[i] <= `BDTS_TAG_NONE;
            pend_r[i] <= 8'h0;
            csize_r[i] <= `BDTS_CSIZE_RST;
            lsw2_r[i] <= 8'h0;
            rmem_r[i] <= 32'h0;
            last_r[i] <= 32'h0;
         end
      end
      else
      begin
         st_r <= st_nxt;
         cur_s_r <= cur_s_nxt;
         sel_r <= sel_nxt;
         tcnt_r <= tcnt_nxt;
         ftag_r <= ftag_nxt;
         len_r <= len_nxt;
         vcnt_r <= vcnt_nxt;
         p2_r <= p2_nxt;
         rtag_r <= rtag_nxt;
         ferr_r <= ferr_nxt;
         pro_r <= pro_nxt;
         nomem_r <= nomem_nxt;
         sw_r <= sw_nxt;
         resp_r <= resp_nxt;
         tag_r <= tag_nxt;
         pend_r <= pend_nxt;
         csize_r <= csize_nxt;
         lsw2_r <= lsw2_nxt;
         rmem_r <= rmem_nxt;
         last_r <= last_nxt;
      end
   end

   // checks on decoded commands and answers
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic ok_c;
   assign ok_c = p1_c[`BDTS_P1_RSV_HI:`BDTS_P1_RSV_LO] == 3'h0;

   property p_abort;
      cmd_we && ok_c && p1_c[`BDTS_P1_ABORT] && !(p1_c[`BDTS_P1_DATA] &&
         p1_c[`BDTS_P1_RETX]) |=> tag_r[$past(s_c)] == `BDTS_TAG_NONE &&
         pend_r[$past(s_c)] == 8'h0 && sw_r == `BDTS_SW_OK;
   endproperty
   a_abort: assert property (p_abort) else $error("abort kept data");
   property p_badp1;
      cmd_we && p1_c[`BDTS_P1_DATA] && p1_c[`BDTS_P1_RETX] |=>
         sw_r == `BDTS_SW_BADP1 && st_r == bdts_pkg::ST_IDLE;
   endproperty
   a_badp1: assert property (p_badp1) else $error("b1 with b3 taken");
   property p_nomem;
      cmd_we && ok_c && !p1_c[`BDTS_P1_ABORT] && p1_c[`BDTS_P1_DATA] &&
         !p1_c[`BDTS_P1_RETX] && nomem_r |=> sw_r == `BDTS_SW_NOMEM;
   endproperty
   a_nomem: assert property (p_nomem) else $error("no 6a84");
   property p_retx;
      cmd_we && ok_c && !p1_c[`BDTS_P1_ABORT] && !p1_c[`BDTS_P1_DATA] &&
         p1_c[`BDTS_P1_RETX] && s_axi_wdata[15:8] == 8'h0 |=>
         resp_r == $past(last_r[s_c]) && sw_r[7:0] == $past(lsw2_r[s_c]);
   endproperty
   a_retx: assert property (p_retx) else $error("resend differs");
   property p_more;
      fetch_c && pend_r[as_c] > 8'h1 |=> sw_r[0] &&
         sw_r[15:8] == `BDTS_SW1_ONGOING;
   endproperty
   a_more: assert property (p_more) else $error("more flag lost");
   property p_pro;
      ans_c ##1 !ans_c [*2] |-> sw_r[3] == $past(pro_r, 3);
   endproperty
   a_pro: assert property (p_pro) else $error("proactive bit");
   property p_badtag;
      end_c && ftag_r != `BDTS_TAG_SC && st_r == bdts_pkg::ST_VAL |=>
         sw_r[4] && tag_r[$past(cur_s_r)] == $past(tag_r[cur_s_r]);
   endproperty
   a_badtag: assert property (p_badtag) else $error("bad tag took");
   property p_done;
      end_c |=> st_r == bdts_pkg::ST_IDLE && sw_r[15:8] == `BDTS_SW1_ONGOING;
   endproperty
   a_done: assert property (p_done) else $error("frame not ended");
endmodule: bdts_core

// >>> src/bdts_pkg.sv
package bdts_pkg;
   // frame parser states, gray along tag, length, long length, value (short-form length to value flips two bits)
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_TAG = 3'h1,
      ST_LEN = 3'h3,
      ST_LEN2 = 3'h2,
      ST_VAL = 3'h6
   } bdts_state_e;
endpackage: bdts_pkg
